// ---- src/osoc_defines.vh ----
// Constants for the octal switch output control block.
`ifndef OSOC_DEFINES_VH
`define OSOC_DEFINES_VH
// APB register byte offsets.
`define OSOC_OFF_SER     12'h000
`define OSOC_OFF_MAP     12'h004
`define OSOC_OFF_BOOL    12'h008
`define OSOC_OFF_OVLD    12'h00c
`define OSOC_OFF_OTMODE  12'h010
`define OSOC_OFF_SLOW    12'h014
`define OSOC_OFF_STATE   12'h018
`define OSOC_OFF_DIAGOT  12'h01c
`define OSOC_OFF_DIAGOL  12'h020
`define OSOC_OFF_CLEAR   12'h024
// Reset values.
`define OSOC_RST_MAP     8'h08
`define OSOC_RST_ZERO    8'h00
// Timing.
`define OSOC_CLK_MHZ     50
`define OSOC_FAST_US     15
`define OSOC_SLOW_US     60
`define OSOC_TOFF_US     10
`define OSOC_FILT_US     50
`define OSOC_CYC(us)     ((us) * `OSOC_CLK_MHZ)
`endif

// ---- src/osoc_top.v ----
// Eight channel low-side switch output control with APB registers.
`timescale 1ns/1ns
`include "osoc_defines.vh"

// Summary of operation
// - Per channel selectable AND or OR combination
// - OR: either request; AND: both requests
// - Output from serial bit or combination
// - Serial bit high active; parallel per polarity pin
// - Mappable input drives mapped channels, default ch4
// - Per channel fast or slow switching time
// - Overtemperature switches channel off, records flag
// - Auto restart after cooling if request held
// - Latching mode waits for new request rise
// - Overtemperature sensed only while channel on
// - Reset low clears outputs, diagnosis, registers except map and state
// - After reset only parallel driven outputs on
// - Limit only mode reports fault after filter
// - Limit plus shutdown switches off after delay
// - Overload latch cleared by request rise
// - Polarity pin high means high active inputs
// - Combination bit zero OR, one AND
// - Overload switch-off delay 10 us, fault filter 50 us
module osoc_top #(
   parameter NCH        = 8,
   parameter FAST_CYC   = `OSOC_CYC(`OSOC_FAST_US),
   parameter SLOW_CYC   = `OSOC_CYC(`OSOC_SLOW_US),
   parameter TOFF_CYC   = `OSOC_CYC(`OSOC_TOFF_US),
   parameter FILT_CYC   = `OSOC_CYC(`OSOC_FILT_US),
   parameter CW         = 13
)(
   input  wire              clock,
   input  wire              rst_b,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [11:0]       paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output reg               pready,
   output reg               pslverr,
   input  wire [2:0]        parallelInput,
   input  wire              mappable_parallel_input,
   input  wire              input_polarity_select,
   input  wire [NCH-1:0]    overTempSense,
   input  wire [NCH-1:0]    currentLimit,
   output reg  [NCH-1:0]    gateOn,
   output reg  [NCH-1:0]    gateSettled,
   output reg               faultFlag
);

   // ----------------------------------------------------------------
   // Pin synchronisers: three stages, a change counts when 2 and 3 agree.
   // ----------------------------------------------------------------
   localparam NPIN = 5 + 2 * NCH;
   // The polarity pin is pulled up, so its stages reset high. A low reset
   // would read as low active inputs and switch channels on right after wake.
   localparam [NPIN-1:0] PIN_IDLE = {{(2 * NCH){1'b0}}, 1'b1, 4'h0};
   wire [NPIN-1:0] pinRaw = {currentLimit, overTempSense, input_polarity_select,
                             mappable_parallel_input, parallelInput};
   reg  [NPIN-1:0] syncA;
   reg  [NPIN-1:0] syncB;
   reg  [NPIN-1:0] syncC;
   reg  [NPIN-1:0] pinVal;
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         syncA  <= PIN_IDLE;
         syncB  <= PIN_IDLE;
         syncC  <= PIN_IDLE;
         pinVal <= PIN_IDLE;
      end
      else
      begin
         syncA  <= pinRaw;
         syncB  <= syncA;
         syncC  <= syncB;
         pinVal <= (syncB & syncC) | (pinVal & (syncB | syncC));
      end
   end
   wire [2:0]     parIn   = pinVal[2:0];
   wire           mapIn   = pinVal[3];
   wire           polHigh = pinVal[4];
   wire [NCH-1:0] otSense = pinVal[5 +: NCH];
   wire [NCH-1:0] curLim  = pinVal[5 + NCH +: NCH];

   // ----------------------------------------------------------------
   // Registers.
   // ----------------------------------------------------------------
   reg  [NCH-1:0] serialCmd;
   reg  [NCH-1:0] inputMap;
   reg  [NCH-1:0] boolAnd;
   reg  [NCH-1:0] ovlShutdown;
   reg  [NCH-1:0] otLatching;
   reg  [NCH-1:0] slowSlew;
   reg  [NCH-1:0] combineMode;
   reg  [NCH-1:0] otLatch;
   reg  [NCH-1:0] ovlLatch;
   reg  [NCH-1:0] otDiag;
   reg  [NCH-1:0] ovlDiag;
   reg  [NCH-1:0] prevReq;

   wire wrEn = psel & penable & pwrite;
   wire rdEn = psel & penable & ~pwrite;
   wire addrOk = (paddr[1:0] == 2'b00) && (paddr <= `OSOC_OFF_CLEAR);
   wire clrEn = wrEn && (paddr == `OSOC_OFF_CLEAR);

   // ----------------------------------------------------------------
   // Request formation.
   // ----------------------------------------------------------------
   // Polarity pin high keeps inputs high active, low inverts them.
   wire [3:0] parAct = polHigh ? {mapIn, parIn} : ~{mapIn, parIn};
   reg  [NCH-1:0] parReq;
   reg  [NCH-1:0] effReq;
   integer i;
   always @*
   begin
      for (i = 0; i < NCH; i = i + 1)
      begin
         // Channels 1 to 3 own a pin; channel 4 has its own pin only through the map.
         parReq[i] = inputMap[i] & parAct[3];
         if (i < 3)
            parReq[i] = parReq[i] | parAct[i];
         if (!combineMode[i])
            effReq[i] = serialCmd[i];
         else if (boolAnd[i])
            effReq[i] = serialCmd[i] & parReq[i];
         else
            effReq[i] = serialCmd[i] | parReq[i];
      end
   end
   wire [NCH-1:0] reqRise = effReq & ~prevReq;
   // Sensors are ignored while the gate is off, so an off channel never trips.
   wire [NCH-1:0] otEvent = otSense & gateOn;
   wire [NCH-1:0] nextGate = effReq & ~otLatch & ~ovlLatch & ~otEvent;

   // ----------------------------------------------------------------
   // Per channel overload and slew timers.
   // ----------------------------------------------------------------
   reg [CW-1:0] limCnt [0:NCH-1];
   reg [CW-1:0] slewCnt [0:NCH-1];
   reg [NCH-1:0] ovlTrip;
   reg [NCH-1:0] ovlFault;
   always @*
   begin
      for (i = 0; i < NCH; i = i + 1)
      begin
         ovlTrip[i]  = ovlShutdown[i] && (limCnt[i] >= TOFF_CYC[CW-1:0]);
         ovlFault[i] = !ovlShutdown[i] && (limCnt[i] >= FILT_CYC[CW-1:0]);
      end
   end

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (i = 0; i < NCH; i = i + 1)
         begin
            limCnt[i]  <= {CW{1'b0}};
            slewCnt[i] <= {CW{1'b0}};
         end
      end
      else
      begin
         for (i = 0; i < NCH; i = i + 1)
         begin
            if (!(curLim[i] & gateOn[i]))
               limCnt[i] <= {CW{1'b0}};
            else if (limCnt[i] != {CW{1'b1}})
               limCnt[i] <= limCnt[i] + 1'b1;
            if (nextGate[i] != gateOn[i])
               slewCnt[i] <= {CW{1'b0}};
            else if (slewCnt[i] != {CW{1'b1}})
               slewCnt[i] <= slewCnt[i] + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Protection, gate drive and registers. Reset low forces the sleep
   // state: outputs off, diagnosis and on/off register cleared.
   // ----------------------------------------------------------------
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         serialCmd   <= `OSOC_RST_ZERO;
         inputMap    <= `OSOC_RST_MAP;
         boolAnd     <= `OSOC_RST_ZERO;
         ovlShutdown <= `OSOC_RST_ZERO;
         otLatching  <= `OSOC_RST_ZERO;
         slowSlew    <= `OSOC_RST_ZERO;
         // Parallel inputs stay in control after wake, so the pins alone drive.
         combineMode <= {NCH{1'b1}};
         otLatch     <= {NCH{1'b0}};
         ovlLatch    <= {NCH{1'b0}};
         otDiag      <= {NCH{1'b0}};
         ovlDiag     <= {NCH{1'b0}};
         prevReq     <= {NCH{1'b0}};
         gateOn      <= {NCH{1'b0}};
         gateSettled <= {NCH{1'b0}};
         faultFlag   <= 1'b0;
      end
      else
      begin
         if (wrEn)
         begin
            case (paddr)
               `OSOC_OFF_SER:    serialCmd   <= pwdata[NCH-1:0];
               `OSOC_OFF_MAP:    inputMap    <= pwdata[NCH-1:0];
               `OSOC_OFF_BOOL:   boolAnd     <= pwdata[NCH-1:0];
               `OSOC_OFF_OVLD:   ovlShutdown <= pwdata[NCH-1:0];
               `OSOC_OFF_OTMODE: otLatching  <= pwdata[NCH-1:0];
               `OSOC_OFF_SLOW:   slowSlew    <= pwdata[NCH-1:0];
               `OSOC_OFF_STATE:  combineMode <= pwdata[NCH-1:0];
               default:          serialCmd   <= serialCmd;
            endcase
         end
         prevReq <= effReq;
         for (i = 0; i < NCH; i = i + 1)
         begin
            // Overtemperature latch: auto restart clears it once cool with the
            // request still on; latching waits for a fresh request rise.
            if (otEvent[i])
               otLatch[i] <= 1'b1;
            else if (!otLatching[i] && !otSense[i] && effReq[i])
               otLatch[i] <= 1'b0;
            else if (!otLatching[i] && !effReq[i])
               otLatch[i] <= 1'b0;
            else if (otLatching[i] && reqRise[i] && !otSense[i])
               otLatch[i] <= 1'b0;
            if (ovlTrip[i])
               ovlLatch[i] <= 1'b1;
            else if (reqRise[i])
               ovlLatch[i] <= 1'b0;
            // Set wins over a software clear in the same cycle.
            if (otEvent[i])
               otDiag[i] <= 1'b1;
            else if (clrEn && pwdata[i])
               otDiag[i] <= 1'b0;
            if (ovlTrip[i] || ovlFault[i])
               ovlDiag[i] <= 1'b1;
            else if (clrEn && pwdata[NCH + i])
               ovlDiag[i] <= 1'b0;
            gateSettled[i] <= slewCnt[i] >= (slowSlew[i] ? SLOW_CYC[CW-1:0]
                                                         : FAST_CYC[CW-1:0]);
         end
         gateOn    <= nextGate;
         faultFlag <= |(otDiag | ovlDiag);
      end
   end

   // ----------------------------------------------------------------
   // APB slave: zero wait states, error on unmapped address.
   // ----------------------------------------------------------------
   reg [31:0] rdMux;
   always @*
   begin
      rdMux = 32'h0000_0000;
      case (paddr)
         `OSOC_OFF_SER:    rdMux[NCH-1:0] = serialCmd;
         `OSOC_OFF_MAP:    rdMux[NCH-1:0] = inputMap;
         `OSOC_OFF_BOOL:   rdMux[NCH-1:0] = boolAnd;
         `OSOC_OFF_OVLD:   rdMux[NCH-1:0] = ovlShutdown;
         `OSOC_OFF_OTMODE: rdMux[NCH-1:0] = otLatching;
         `OSOC_OFF_SLOW:   rdMux[NCH-1:0] = slowSlew;
         `OSOC_OFF_STATE:  rdMux = {16'h0000, gateOn, combineMode};
         `OSOC_OFF_DIAGOT: rdMux[NCH-1:0] = otDiag;
         `OSOC_OFF_DIAGOL: rdMux[NCH-1:0] = ovlDiag;
         default:          rdMux = 32'h0000_0000;
      endcase
   end

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         // Answer in the first cycle of the access phase; pready drops after it.
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~addrOk;
         if (psel & ~penable & ~pwrite)
            prdata <= rdMux;
         else if (rdEn & pready)
            prdata <= 32'h0000_0000;
      end
   end

endmodule // osoc_top

// ---- bench/osoc_checker.sv ----
// Concurrent checks on the ports of the output control block.
`timescale 1ns/1ns
module osoc_checker #(
   parameter NCH      = 8,
   parameter SLOW_CYC = 3000
)(
   input wire logic           clock,
   input wire logic           rst_b,
   input wire logic           psel,
   input wire logic           penable,
   input wire logic           pwrite,
   input wire logic [11:0]    paddr,
   input wire logic [31:0]    prdata,
   input wire logic           pready,
   input wire logic           pslverr,
   input wire logic [NCH-1:0] overTempSense,
   input wire logic [NCH-1:0] gateOn,
   input wire logic [NCH-1:0] gateSettled,
   input wire logic           faultFlag
);
   // A restarted slew count may add a few cycles on top of the slow time.
   localparam int SB = SLOW_CYC + 8;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   sleep_clear_a: assert property ($rose(rst_b) |-> gateOn == 0 && !faultFlag)
      else $error("Outputs or fault not clear after sleep");
   ready_on_time_a: assert property (psel && !penable |=> pready)
      else $error("No ready in access cycle");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("Ready outside access cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("Ready longer than one cycle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("Slave error without ready");
   bad_addr_err_a: assert property (psel && !penable && paddr > 12'h024 |=> pslverr)
      else $error("Unmapped address not refused");
   err_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 0)
      else $error("Refused read returned data");
   ot_cutoff_a: assert property ($rose(overTempSense[0]) && gateOn[0] |-> ##[1:8] !gateOn[0])
      else $error("Hot channel not switched off");
   settle_bound_a: assert property ($fell(gateSettled[0]) |-> ##[1:SB] gateSettled[0])
      else $error("Switching time exceeded");
endmodule // osoc_checker

// ---- bench/osoc_mcu_pins.sv ----
// Controller-side model that drives the parallel channel pins.
`timescale 1ns/1ns
module osoc_mcu_pins (
   input  wire logic       clock,
   input  wire logic [3:0] req,
   input  wire logic       pol,
   output logic [2:0]      parallelInput = 3'h0,
   output logic            mappable_parallel_input = 1'h0,
   output logic            input_polarity_select = 1'h1
);
   // A request becomes the pin level that the polarity pin calls active.
   always @(posedge clock)
   begin
      input_polarity_select   <= pol;
      parallelInput           <= pol ? req[2:0] : ~req[2:0];
      mappable_parallel_input <= pol ? req[3] : ~req[3];
   end
endmodule // osoc_mcu_pins

// ---- bench/tb_top.sv ----
// Self-checking testbench for the octal switch output control block.
`timescale 1ns/1ns
`include "osoc_defines.vh"
module tb_top;
   logic        clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pslverr, err, faultFlag, pol = 1, mapIn, polSel;
   logic [3:0]  req = 4'h1;
   logic [2:0]  parIn;
   logic [7:0]  ot = 0, lim = 0, gateOn, gateSettled;
   int          num_errors = 0, comparisons = 0;
   always #10 clock = ~clock;
   osoc_top #(.FAST_CYC(4), .SLOW_CYC(8), .TOFF_CYC(3), .FILT_CYC(6)) i_osoc_top (
      .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .parallelInput(parIn), .mappable_parallel_input(mapIn),
      .input_polarity_select(polSel), .overTempSense(ot), .currentLimit(lim),
      .gateOn(gateOn), .gateSettled(gateSettled), .faultFlag(faultFlag));
   osoc_mcu_pins i_osoc_mcu_pins (.clock(clock), .req(req), .pol(pol),
      .parallelInput(parIn), .mappable_parallel_input(mapIn),
      .input_polarity_select(polSel));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      do @(posedge clock); while (pready !== 1'b1 && n++ < 20);
      chk({31'h0, pready}, 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clock);
   endtask
   // Pins pass a synchroniser, so the gate is given settling time first.
   task wait_gate(input logic [7:0] e);
      int n;
      n = 0;
      repeat (8) @(posedge clock);
      while (gateOn !== e && n++ < 40) @(posedge clock);
      chk({24'h0, gateOn}, {24'h0, e});
   endtask
   task print_verdict;
      $display("Errors %0d, comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_reset;
      wait_gate(8'h01);
      apb(0, `OSOC_OFF_MAP, 0);
      chk(rd, 32'h08);
      apb(0, `OSOC_OFF_STATE, 0);
      chk(rd, 32'h01ff);
      apb(0, 12'h028, 0);
      chk({rd[31:1], err}, 32'h1);
   endtask
   task t_serial;
      req <= 0;
      apb(1, `OSOC_OFF_STATE, 0);
      apb(1, `OSOC_OFF_SER, 8'h81);
      wait_gate(8'h81);
   endtask
   task t_bool;
      logic [2:0] k;
      apb(1, `OSOC_OFF_STATE, 1);
      for (int i = 0; i < 16; i++)
      begin
         k = i[3:1];
         pol <= i[3];
         req[0] <= k[0];
         apb(1, `OSOC_OFF_BOOL, i[2]);
         apb(1, `OSOC_OFF_SER, i[0]);
         wait_gate(i[2] ? (i[1] & i[0]) : (i[1] | i[0]));
      end
      req <= 0;
   endtask
   task t_map;
      apb(1, `OSOC_OFF_STATE, 8'hff);
      apb(1, `OSOC_OFF_BOOL, 0);
      apb(1, `OSOC_OFF_SER, 0);
      apb(1, `OSOC_OFF_MAP, 8'hf0);
      req <= 4'h8;
      wait_gate(8'hf0);
      req <= 0;
      apb(1, `OSOC_OFF_MAP, 8'h08);
   endtask
   task t_ot;
      apb(1, `OSOC_OFF_STATE, 0);
      apb(1, `OSOC_OFF_SER, 1);
      wait_gate(8'h01);
      ot <= 8'h03;
      wait_gate(8'h00);
      apb(0, `OSOC_OFF_DIAGOT, 0);
      chk(rd, 32'h1);
      chk(faultFlag, 1);
      ot <= 0;
      wait_gate(8'h01);
      apb(1, `OSOC_OFF_OTMODE, 1);
      apb(1, `OSOC_OFF_CLEAR, 32'hff);
      ot <= 8'h01;
      wait_gate(8'h00);
      ot <= 0;
      wait_gate(8'h00);
      apb(1, `OSOC_OFF_SER, 0);
      apb(1, `OSOC_OFF_SER, 1);
      wait_gate(8'h01);
   endtask
   task t_ol;
      apb(1, `OSOC_OFF_CLEAR, 32'hffff);
      apb(1, `OSOC_OFF_OVLD, 1);
      apb(1, `OSOC_OFF_SER, 3);
      wait_gate(8'h03);
      lim <= 8'h03;
      wait_gate(8'h02);
      repeat (12) @(posedge clock);
      apb(0, `OSOC_OFF_DIAGOL, 0);
      chk(rd, 32'h3);
      lim <= 0;
      wait_gate(8'h02);
      apb(1, `OSOC_OFF_SER, 2);
      apb(1, `OSOC_OFF_SER, 3);
      wait_gate(8'h03);
   endtask
   task t_sleep;
      rst_b <= 0;
      @(posedge clock);
      chk({24'h0, gateOn}, 32'h0);
      rst_b <= 1;
      @(posedge clock);
      apb(0, `OSOC_OFF_DIAGOL, 0);
      chk(rd, 32'h0);
      apb(0, `OSOC_OFF_SER, 0);
      chk(rd, 32'h0);
   endtask
   initial
   begin
      repeat (10) @(posedge clock);
      rst_b <= 1;
      @(posedge clock);
      t_reset;
      t_serial;
      t_bool;
      t_map;
      t_ot;
      t_ol;
      t_sleep;
      print_verdict;
   end
   initial
   begin
      repeat (20000) @(posedge clock);
      num_errors++;
      print_verdict;
   end
endmodule // tb_top
bind osoc_top osoc_checker #(.NCH(NCH), .SLOW_CYC(SLOW_CYC)) i_osoc_checker (
   .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .overTempSense(overTempSense), .gateOn(gateOn), .gateSettled(gateSettled),
   .faultFlag(faultFlag));
